// File: hdl/scd_pkg.sv
// Constants and types shared by the start-up delay and clock divider
package scd_pkg;

  localparam int         CLK_KHZ       = 20000;
  localparam int         SYNC_STAGES   = 2;
  localparam int         CNT_W         = 21;

  localparam logic [3:0] ADR_DIV       = 4'h0;
  localparam logic [3:0] ADR_CSEL      = 4'h4;
  localparam logic [3:0] ADR_STAT      = 4'h8;

  localparam int         DIV_CE_POS    = 7;
  localparam logic [7:0] DIV_UNLOCK    = 8'h80;
  localparam logic [3:0] DIV_RST_PLAIN = 4'h0;
  localparam logic [3:0] DIV_RST_DIV8  = 4'h3;
  localparam logic [3:0] DIV_MAX_CODE  = 4'h8;
  localparam logic [2:0] CE_WINDOW     = 3'h4;

  localparam int         CSEL_SRC_POS  = 0;
  localparam int         CSEL_SUT_POS  = 1;
  localparam int         CSEL_LF_POS   = 3;
  localparam int         CSEL_USE_POS  = 7;
  localparam int         STAT_ST_POS   = 0;
  localparam int         STAT_OSC_POS  = 3;
  localparam int         STAT_CE_POS   = 4;

  localparam int         RST_BASE_CYC  = 14;
  localparam int         WAKE_258_CYC  = 258;
  localparam int         WAKE_1K_CYC   = 1024;
  localparam int         WAKE_16K_CYC  = 16384;
  localparam int         WAKE_32K_CYC  = 32768;
  localparam int         DLY_SHORT_US  = 4100;
  localparam int         DLY_LONG_US   = 65000;
  localparam int         DLY_SHORT_CYC = DLY_SHORT_US * (CLK_KHZ / 1000);
  localparam int         DLY_LONG_CYC  = DLY_LONG_US * (CLK_KHZ / 1000);

  typedef enum logic [2:0] {
    ST_CAPTURE = 3'b000,
    ST_RST_DLY = 3'b001,
    ST_RUN     = 3'b010,
    ST_SLEEP   = 3'b011,
    ST_WAKE    = 3'b100
  } scd_state_type;

  typedef struct packed {
    logic       lf;
    logic [1:0] sut;
    logic       src;
  } scd_cfg_type;

  typedef struct packed {
    logic       source_select_fuse_bit0;
    logic [1:0] startup_time_fuses;
    logic       lf_crystal_fuse;
    logic       reset_pin_disable_fuse;
    logic       divide_by_eight_fuse;
  } scd_fuse_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } scd_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } scd_wb_rsp_type;

endpackage

// File: hdl/scd_sync.sv
// Two-stage synchroniser for a group of slow or asynchronous inputs
module scd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } scd_sync_regs_type;

  scd_sync_regs_type r_ff;
  scd_sync_regs_type nxt_r;

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.meta = d_i;
    nxt_r.sync = r_ff.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else if (ce_i) begin
      r_ff <= nxt_r;
    end
  end

  assign q_o = r_ff.sync;

endmodule

// File: hdl/scd_top.sv
// Start-up delay sequencer and system clock divider with Wishbone registers
// Contract
// [RULE1] Crystal wake delay: 258, 1024 or 16384 cycles
// [RULE2] Reset adds 14 cycles plus 0/4.1/65 ms
// [RULE3] Delay-free codes only without reset-pin disable
// [RULE4] Low-frequency crystal: 1024/32768 cycles, 4.1/65 ms
// [RULE5] 32 kHz oscillator for timer when allowed
// [RULE6] Change enable set only with others zero
// [RULE7] Change enable clears after four cycles or load
// [RULE8] Rewrite inside window changes nothing
// [RULE9] Divider bits 6:4 read zero
// [RULE10] Divider field sets system clock ratio
// [RULE11] Software unlocks then writes divider within four
// [RULE12] Software masks interrupts during divider change
// [RULE13] Divider resets to 0000 or 0011 by fuse
// [RULE14] Any divider value accepted after unlock
// [RULE15] Codes 0-8 divide by 1 to 256
// [RULE16] System clock gated until delays elapse
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
module scd_top #(
  parameter int WAKE_16K = scd_pkg::WAKE_16K_CYC,
  parameter int WAKE_32K = scd_pkg::WAKE_32K_CYC,
  parameter int DLY_SHORT = scd_pkg::DLY_SHORT_CYC,
  parameter int DLY_LONG = scd_pkg::DLY_LONG_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire scd_pkg::scd_wb_req_type wb_i,
  output scd_pkg::scd_wb_rsp_type      wb_o,
  input  wire scd_pkg::scd_fuse_type   fuse_i,
  input  wire logic                    wake_i,
  input  wire logic                    ext_clk_en_i,
  input  wire logic                    sleep_req_i,
  input  wire logic                    async_timer_req_i,
  output logic                         sys_clk_en_o,
  output logic                         osc32k_en_o,
  output logic                         running_o
);
  import scd_pkg::*;

  typedef struct packed {
    scd_state_type    st;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       dsel;
    logic             ce;
    logic [2:0]       win;
    logic             use_reg;
    scd_cfg_type      csel;
    logic [7:0]       presc;
    logic             tick;
    logic             osc;
    logic             ack;
    logic [7:0]       rdat;
  } scd_regs_type;

  localparam scd_regs_type REGS_RST = '{
    st: ST_CAPTURE, cnt: CNT_W'(SYNC_STAGES), dsel: DIV_RST_PLAIN,
    ce: 1'b0, win: 3'h0, use_reg: 1'b0, csel: '0, presc: 8'h00,
    tick: 1'b0, osc: 1'b0, ack: 1'b0, rdat: 8'h00};

  scd_regs_type     r_ff;
  scd_regs_type     nxt_r;
  scd_fuse_type     fuse_s;
  logic             wake_s;
  logic             ext_en_s;
  scd_cfg_type      cfg_c;
  logic             req_c;
  logic             wr_c;
  logic             wr_div_c;
  logic [7:0]       wdat_c;
  logic [7:0]       rmux_c;
  logic [7:0]       mask_c;
  logic             tick_c;
  logic             hf_run_c;
  logic [CNT_W-1:0] wake_cyc_c;
  logic [CNT_W-1:0] rst_cyc_c;

  scd_sync #(
    .WIDTH($bits(scd_fuse_type) + 2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i (ce_i),
    .d_i  ({fuse_i, wake_i, ext_clk_en_i}),
    .q_o  ({fuse_s, wake_s, ext_en_s})
  );

  // Wake-up delay from power-down or power-save, in oscillator cycles
  function automatic logic [CNT_W-1:0] wake_cycles(scd_cfg_type c);
    logic [CNT_W-1:0] v;
    v = CNT_W'(WAKE_1K_CYC);
    if (c.lf) begin
      if (c.sut[1]) begin
        v = CNT_W'(WAKE_32K); // RULE4
      end
    end else begin
      case ({c.src, c.sut})
        3'b000, 3'b001: v = CNT_W'(WAKE_258_CYC); // RULE1
        3'b010, 3'b011, 3'b100: v = CNT_W'(WAKE_1K_CYC); // RULE1
        default: v = CNT_W'(WAKE_16K); // RULE1
      endcase
    end
    return v;
  endfunction

  // Delay added after a reset, base cycles included
  function automatic logic [CNT_W-1:0] rst_cycles(scd_cfg_type c,
                                                  logic rst_dis);
    logic [CNT_W-1:0] v;
    v = CNT_W'(RST_BASE_CYC + DLY_LONG);
    if (c.lf) begin
      if (c.sut == 2'b00) begin
        v = CNT_W'(RST_BASE_CYC + DLY_SHORT); // RULE4
      end
    end else begin
      case ({c.src, c.sut})
        3'b000, 3'b011, 3'b110: v = CNT_W'(RST_BASE_CYC + DLY_SHORT); // RULE2
        3'b010, 3'b101: begin
          if (rst_dis) begin
            v = CNT_W'(RST_BASE_CYC + DLY_SHORT); // RULE3
          end else begin
            v = CNT_W'(RST_BASE_CYC); // RULE2
          end
        end
        default: v = CNT_W'(RST_BASE_CYC + DLY_LONG); // RULE2
      endcase
    end
    return v;
  endfunction

  always_comb begin
    cfg_c.lf  = fuse_s.lf_crystal_fuse;
    cfg_c.sut = fuse_s.startup_time_fuses;
    cfg_c.src = fuse_s.source_select_fuse_bit0;
    if (r_ff.use_reg) begin
      cfg_c = r_ff.csel;
    end
  end

  assign wake_cyc_c = wake_cycles(cfg_c);
  assign rst_cyc_c  = rst_cycles(cfg_c, fuse_s.reset_pin_disable_fuse);

  // Writes commit on the edge that sees ack high, while the master
  // still holds address, data and strobe unchanged
  assign req_c    = wb_i.cyc & wb_i.stb;
  assign wr_c     = req_c & r_ff.ack & wb_i.we & wb_i.sel[0];
  assign wr_div_c = wr_c & (wb_i.adr == ADR_DIV);
  assign wdat_c   = wb_i.dat[7:0];

  // Reserved divider codes divide like the largest valid code
  assign mask_c = (r_ff.dsel > DIV_MAX_CODE) ? 8'hFF :
                  8'((9'h001 << r_ff.dsel) - 9'h001); // RULE15
  assign tick_c = (r_ff.presc | ~mask_c) == 8'hFF; // RULE10

  // The high-frequency source counts as running outside sleep
  assign hf_run_c = ~cfg_c.lf & (r_ff.st != ST_SLEEP);

  always_comb begin
    rmux_c = 8'h00;
    case (wb_i.adr)
      ADR_DIV:  rmux_c = {r_ff.ce, 3'b000, r_ff.dsel}; // RULE9
      ADR_CSEL: begin
        rmux_c[CSEL_USE_POS] = r_ff.use_reg;
        rmux_c[CSEL_LF_POS]  = r_ff.csel.lf;
        rmux_c[CSEL_SUT_POS +: 2] = r_ff.csel.sut;
        rmux_c[CSEL_SRC_POS] = r_ff.csel.src;
      end
      ADR_STAT: begin
        rmux_c[STAT_ST_POS +: 3] = r_ff.st;
        rmux_c[STAT_OSC_POS] = r_ff.osc;
        rmux_c[STAT_CE_POS]  = r_ff.ce;
      end
      default:  rmux_c = 8'h00;
    endcase
  end

  always_comb begin
    nxt_r       = r_ff;
    nxt_r.ack   = req_c & ~r_ff.ack;
    nxt_r.tick  = 1'b0;
    nxt_r.presc = 8'(r_ff.presc + 8'h01);
    nxt_r.osc   = async_timer_req_i & (~hf_run_c | ~ext_en_s); // RULE5
    if (req_c & ~r_ff.ack) begin
      nxt_r.rdat = rmux_c;
    end
    if (r_ff.ce) begin
      if (r_ff.win == 3'h1) begin
        nxt_r.ce = 1'b0; // RULE7
      end else begin
        nxt_r.win = 3'(r_ff.win - 3'h1);
      end
    end
    if (wr_div_c) begin
      if (!r_ff.ce) begin
        if (wdat_c == DIV_UNLOCK) begin
          nxt_r.ce  = 1'b1; // RULE6
          nxt_r.win = CE_WINDOW;
        end
      end else if (!wdat_c[DIV_CE_POS]) begin
        nxt_r.dsel  = wdat_c[3:0]; // RULE14
        nxt_r.ce    = 1'b0; // RULE7
        nxt_r.presc = 8'h00;
      end
    end
    if (wr_c & (wb_i.adr == ADR_CSEL)) begin
      nxt_r.use_reg  = wdat_c[CSEL_USE_POS];
      nxt_r.csel.lf  = wdat_c[CSEL_LF_POS];
      nxt_r.csel.sut = wdat_c[CSEL_SUT_POS +: 2];
      nxt_r.csel.src = wdat_c[CSEL_SRC_POS];
    end
    case (r_ff.st)
      ST_CAPTURE: begin
        if (r_ff.cnt == '0) begin
          nxt_r.dsel = fuse_s.divide_by_eight_fuse ? DIV_RST_DIV8 :
                       DIV_RST_PLAIN; // RULE13
          nxt_r.st   = ST_RST_DLY;
          nxt_r.cnt  = CNT_W'(rst_cyc_c - 1'b1); // RULE2
        end else begin
          nxt_r.cnt = CNT_W'(r_ff.cnt - 1'b1);
        end
      end
      ST_RST_DLY, ST_WAKE: begin
        if (r_ff.cnt == '0) begin
          nxt_r.st    = ST_RUN; // RULE16
          nxt_r.presc = 8'h00;
        end else begin
          nxt_r.cnt = CNT_W'(r_ff.cnt - 1'b1);
        end
      end
      ST_RUN: begin
        nxt_r.tick = tick_c; // RULE10
        if (sleep_req_i) begin
          nxt_r.st   = ST_SLEEP;
          nxt_r.tick = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (wake_s) begin
          nxt_r.st  = ST_WAKE;
          nxt_r.cnt = CNT_W'(wake_cyc_c - 1'b1); // RULE1
        end
      end
      default: nxt_r.st = ST_CAPTURE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= REGS_RST;
    end else if (ce_i) begin
      r_ff <= nxt_r;
    end
  end

  assign wb_o.ack     = r_ff.ack;
  assign wb_o.dat     = {24'h000000, r_ff.rdat};
  assign sys_clk_en_o = r_ff.tick;
  assign osc32k_en_o  = r_ff.osc;
  assign running_o    = (r_ff.st == ST_RUN);

  // Checks assume ce_i stays high
  sequence unlock_s;
    wr_div_c && !r_ff.ce && wdat_c == DIV_UNLOCK;
  endsequence

  sequence quiet_window_s;
    (!wr_div_c) [*4];
  endsequence

  property unlock_p;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      unlock_s |=> r_ff.ce && r_ff.win == CE_WINDOW;
  endproperty

  property window_len_p;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      $rose(r_ff.ce) ##0 quiet_window_s |=> !r_ff.ce;
  endproperty

  unlock_set_a: assert property (unlock_p) // RULE6
    else $error("change enable not set by unlock write");

  unlock_reject_a: assert property ( // RULE6
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      wr_div_c && !r_ff.ce && wdat_c != DIV_UNLOCK |=> !r_ff.ce)
    else $error("change enable set by a bad write");

  window_len_a: assert property (window_len_p) // RULE7
    else $error("change enable window not four cycles");

  window_hold_a: assert property ( // RULE7
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      $rose(r_ff.ce) |-> r_ff.ce ##1 (r_ff.ce || $past(wr_div_c)))
    else $error("change enable dropped too early");

  rewrite_keep_a: assert property ( // RULE8
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      r_ff.ce && r_ff.win > 3'h1 && wr_div_c && wdat_c[DIV_CE_POS]
      |=> r_ff.ce && r_ff.win == $past(r_ff.win) - 3'h1)
    else $error("rewrite changed the window");

  div_load_a: assert property ( // RULE14
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      r_ff.ce && wr_div_c && !wdat_c[DIV_CE_POS]
      |=> !r_ff.ce && r_ff.dsel == $past(wdat_c[3:0]))
    else $error("divider not loaded in window");

  div_locked_a: assert property ( // RULE10
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      !r_ff.ce && r_ff.st != ST_CAPTURE |=> $stable(r_ff.dsel))
    else $error("divider changed while locked");

  rsv_zero_a: assert property ( // RULE9
    @(posedge clk_i) disable iff (rst_i)
      $rose(wb_o.ack) && $past(wb_i.adr) == ADR_DIV |-> wb_o.dat[6:4] == 3'h0)
    else $error("reserved divider bits not zero");

  div_rate_a: assert property ( // RULE15
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      sys_clk_en_o && r_ff.dsel == 4'h1 && r_ff.st == ST_RUN && !wr_div_c
      && !sleep_req_i |=> !sys_clk_en_o ##1 (sys_clk_en_o || !running_o))
    else $error("divide by two rate wrong");

  clk_gate_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
      !$past(running_o) |-> !sys_clk_en_o)
    else $error("system clock enabled during start-up");

  div_reset_a: assert property ( // RULE13
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      r_ff.st == ST_CAPTURE && r_ff.cnt == '0 |=> r_ff.dsel ==
      ($past(fuse_s.divide_by_eight_fuse) ? DIV_RST_DIV8 : DIV_RST_PLAIN))
    else $error("divider reset value wrong");

  rst_pin_a: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      r_ff.st == ST_CAPTURE && r_ff.cnt == '0 && fuse_s.reset_pin_disable_fuse
      |=> r_ff.cnt >= CNT_W'(RST_BASE_CYC + DLY_SHORT - 1))
    else $error("delay-free code used with reset pin disabled");

  osc_allow_a: assert property ( // RULE5
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      osc32k_en_o |-> $past(!hf_run_c || !ext_en_s))
    else $error("32 kHz oscillator enabled while not allowed");

endmodule

// File: sim/scd_osc_model.sv
// Behavioural clock source and fuse array facing the clock control block
module scd_osc_model (
  input  wire logic                  clk_i,
  input  wire scd_pkg::scd_fuse_type fuse_cfg_i,
  input  wire logic                  ext_on_i,
  input  wire logic                  wake_go_i,
  input  wire logic [7:0]            wake_dly_i,
  input  wire logic                  running_i,
  output scd_pkg::scd_fuse_type      fuse_o,
  output logic                       ext_clk_en_o,
  output logic                       wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import scd_pkg::*;
  logic [7:0] cnt_ff  = 8'h00;
  logic       arm_ff  = 1'b0;
  logic       wake_ff = 1'b0;
  assign wake_o       = wake_ff;
  assign fuse_o       = fuse_cfg_i;
  assign ext_clk_en_o = ext_on_i;
  // Wake answers after a chosen delay and stays up until the block runs
  always @(posedge clk_i) begin
    if (wake_go_i) begin
      cnt_ff <= wake_dly_i;
      arm_ff <= 1'b1;
    end else if (arm_ff && cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end else if (arm_ff) begin
      wake_ff <= 1'b1;
      arm_ff  <= 1'b0;
    end else if (running_i) begin
      wake_ff <= 1'b0;
    end
  end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the start-up delay and clock divider block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import scd_pkg::*;
  localparam int W16 = 40;
  localparam int W32 = 80;
  localparam int DS  = 20;
  localparam int DL  = 30;
  logic           clk_i     = 1'b0;
  logic           rst_i     = 1'b1;
  logic           ce_i      = 1'b1;
  logic           sleep_i   = 1'b0;
  logic           atr_i     = 1'b0;
  logic           ext_on    = 1'b0;
  logic           wake_go   = 1'b0;
  logic [7:0]     wdly      = 8'h05;
  scd_fuse_type   fcfg      = 6'h01;
  scd_wb_req_type wb        = '0;
  scd_wb_rsp_type wbr;
  scd_fuse_type   fuse;
  logic           wake;
  logic           ext_en;
  logic           sclk;
  logic           osc32;
  logic           run;
  int             err_total = 0;
  int             n_tests   = 0;

  scd_top #(.WAKE_16K(W16), .WAKE_32K(W32), .DLY_SHORT(DS), .DLY_LONG(DL))
  u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb), .wb_o(wbr),
    .fuse_i(fuse), .wake_i(wake), .ext_clk_en_i(ext_en),
    .sleep_req_i(sleep_i), .async_timer_req_i(atr_i),
    .sys_clk_en_o(sclk), .osc32k_en_o(osc32), .running_o(run));

  scd_osc_model u_osc (.clk_i(clk_i), .fuse_cfg_i(fcfg), .ext_on_i(ext_on),
    .wake_go_i(wake_go), .wake_dly_i(wdly), .running_i(run),
    .fuse_o(fuse), .ext_clk_en_o(ext_en), .wake_o(wake));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask

  // Delays may show a few cycles of synchroniser latency on top
  task automatic chk_rng(input string nm, input int lo, input int g);
    n_tests++;
    if (g < lo || g > lo + 6) begin
      err_total++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, lo + 6, g);
    end
  endtask

  task automatic xfer(input logic we, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{1'b1, 1'b1, we, a, 4'hF, {24'h000000, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wbr.ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 1, 0);
    q = wbr.dat[7:0];
    wb <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask

  task automatic load(input logic [7:0] v);
    wr(ADR_DIV, DIV_UNLOCK);
    wr(ADR_DIV, v);
  endtask

  task automatic per(input int e);
    int n;
    n = 0;
    while (sclk !== 1'b1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sclk !== 1'b1 && n < 600);
    chk("period", e, n);
  endtask

  // A nonzero off freezes the block that many cycles during the delay
  task automatic boot(input scd_fuse_type f, input int lo, input int off);
    int n;
    fcfg  <= f;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      ce_i <= (n <= 4 || n > 4 + off);
      if (run !== 1'b1) chk("gated", 0, sclk);
    end while (run !== 1'b1 && n < 200);
    chk_rng("boot", lo + off, n);
  endtask

  task automatic nap(input logic [7:0] cs, input int lo);
    int n;
    wr(ADR_CSEL, cs);
    repeat (4) @(posedge clk_i);
    chk("osc_run", cs[3], osc32);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    sleep_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("osc_slp", 1, osc32);
    chk("slept", 0, run);
    wake_go <= 1'b1;
    @(posedge clk_i);
    wake_go <= 1'b0;
    n = 0;
    while (wake !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (run !== 1'b1 && n < 40000);
    chk_rng("wake", lo, n);
  endtask

  initial begin
    boot(6'h01, 14 + DS, 0);
    rd("div_rst", ADR_DIV, 8'h03);
    rd("csel_rst", ADR_CSEL, 8'h00);
    wr(4'hC, 8'h5A);
    rd("unmapped", 4'hC, 8'h00);
    per(8);
    wr(ADR_DIV, 8'h81);
    rd("ce_refused", ADR_STAT, 8'h02);
    rd("div_keep", ADR_DIV, 8'h03);
    wr(ADR_DIV, DIV_UNLOCK);
    rd("ce_set", ADR_STAT, 8'h12);
    wr(ADR_DIV, 8'h07);
    rd("div_late", ADR_DIV, 8'h03);
    wr(ADR_DIV, DIV_UNLOCK);
    wr(ADR_DIV, DIV_UNLOCK);
    wr(ADR_DIV, 8'h02);
    rd("div_norestart", ADR_DIV, 8'h03);
    for (int k = 0; k < 10; k++) begin
      load(8'(k));
      rd("div_val", ADR_DIV, 8'(k));
      per(k > 8 ? 256 : 1 << k);
    end
    atr_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("osc_ext_off", 1, osc32);
    ext_on <= 1'b1;
    nap(8'h80, WAKE_258_CYC);
    nap(8'h84, WAKE_1K_CYC);
    nap(8'h83, W16);
    nap(8'h88, WAKE_1K_CYC);
    nap(8'h8C, W32);
    boot(6'h28, 14, 0);
    rd("div_plain", ADR_DIV, 8'h00);
    boot(6'h2A, 14 + DS, 0);
    boot(6'h0C, 14 + DL, 0);
    boot(6'h08, 14 + DL, 8);
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
endmodule
